// File: logic/clk_stop_pkg.sv
// Constants for the differential clock stop and power-down controller.
package clk_stop_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h01;
  localparam logic [7:0] OFS_STOPPABLE = 8'h02;
  localparam logic [7:0] OFS_REV_VENDOR = 8'h04;
  localparam logic [7:0] OFS_PART_ID = 8'h05;
  localparam logic [7:0] OFS_BYTE_COUNT = 8'h06;
  // ==========================================================================
  // Field positions
  localparam int POWERDOWN_DRIVE_SEL_BIT = 7;
  localparam int STOP_MODE_BIT = 6;
  localparam int NUM_OUT = 4;
  // ==========================================================================
  // Values after reset
  localparam logic [7:0] MODE_RST = 8'h07;
  localparam logic [7:0] ENABLE_RST = 8'h66;
  localparam logic [7:0] STOPPABLE_RST = 8'h00;
  localparam logic [7:0] BYTE_COUNT_RST = 8'h07;
  // Identity codes: the values are arbitrary.
  localparam logic [3:0] REVISION_CODE = 4'h2;
  localparam logic [3:0] VENDOR_CODE = 4'h3;
  localparam logic [7:0] PART_ID_RST = 8'h5A;
  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int LOCK_TIME_US = 1000;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
  localparam logic [1:0] DEBOUNCE_EDGES = 2'h2;
  // ==========================================================================
  // Power sequencing states
  typedef enum logic [3:0] {
    PWR_RUN = 4'h1,
    PWR_PARK = 4'h2,
    PWR_DOWN = 4'h4,
    PWR_LOCK = 4'h8
  } pwr_state_e;
endpackage : clk_stop_pkg

// File: logic/diff_clock_stop_powerdown_ctrl.sv
// Power-down and output-stop gating for a four-pair differential clock buffer.
`timescale 1ns/1ps
`default_nettype none
module diff_clock_stop_powerdown_ctrl #(
  parameter int LOCK_CYCLES = clk_stop_pkg::LOCK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Reference clock and control pins
  input wire logic ref_clock_in,
  input wire logic power_down_n,
  input wire logic output_stop_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  // Differential output pairs
  output logic [3:0] diff_out_true,
  output logic [3:0] diff_out_true_oe,
  output logic [3:0] diff_out_comp,
  output logic [3:0] diff_out_comp_oe,
  output logic [3:0] true_half_drive,
  output logic pll_locked
);
  // ==========================================================================
  // Registers
  logic [7:0] mode_r;
  logic [7:0] enable_r;
  logic [7:0] stoppable_r;
  logic [7:0] part_id_r;
  logic [7:0] byte_count_r;
  logic powerdown_drive_sel;
  logic stop_mode;

  assign powerdown_drive_sel = mode_r[clk_stop_pkg::POWERDOWN_DRIVE_SEL_BIT];
  assign stop_mode = mode_r[clk_stop_pkg::STOP_MODE_BIT];

  // The revision/vendor byte has no storage, so writes to it fall away.
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_r <= clk_stop_pkg::MODE_RST;
      enable_r <= clk_stop_pkg::ENABLE_RST;
      stoppable_r <= clk_stop_pkg::STOPPABLE_RST;
      part_id_r <= clk_stop_pkg::PART_ID_RST;
      byte_count_r <= clk_stop_pkg::BYTE_COUNT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        clk_stop_pkg::OFS_MODE: mode_r <= reg_wdata;
        clk_stop_pkg::OFS_ENABLE: enable_r <= reg_wdata;
        clk_stop_pkg::OFS_STOPPABLE: stoppable_r <= reg_wdata;
        clk_stop_pkg::OFS_PART_ID: part_id_r <= reg_wdata;
        clk_stop_pkg::OFS_BYTE_COUNT: byte_count_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        clk_stop_pkg::OFS_MODE: reg_rdata <= mode_r;
        clk_stop_pkg::OFS_ENABLE: reg_rdata <= enable_r;
        clk_stop_pkg::OFS_STOPPABLE: reg_rdata <= stoppable_r;
        clk_stop_pkg::OFS_REV_VENDOR: reg_rdata <= {clk_stop_pkg::REVISION_CODE,
                                                     clk_stop_pkg::VENDOR_CODE};
        clk_stop_pkg::OFS_PART_ID: reg_rdata <= part_id_r;
        clk_stop_pkg::OFS_BYTE_COUNT: reg_rdata <= byte_count_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Output clock edges
  logic base_r;
  logic comp_rise;
  logic comp_fall;

  always_ff @(posedge mclk) begin
    if (rst) begin
      base_r <= 1'b0;
    end else begin
      base_r <= ref_clock_in;
    end
  end

  // The complement output is the inverse of the true clock.
  assign comp_rise = base_r & ~ref_clock_in;
  assign comp_fall = ~base_r & ref_clock_in;

  // ==========================================================================
  // Power-down sequencing
  clk_stop_pkg::pwr_state_e state_r;
  logic [1:0] pd_cnt_r;
  logic [13:0] lock_cnt_r;

  always_ff @(posedge mclk) begin
    if (rst || state_r != clk_stop_pkg::PWR_RUN || power_down_n) begin
      pd_cnt_r <= 2'h0;
    end else if (comp_rise && pd_cnt_r != clk_stop_pkg::DEBOUNCE_EDGES) begin
      pd_cnt_r <= pd_cnt_r + 2'h1;
    end
  end

  // Release is taken at once: the output clock is parked then and cannot
  // serve as a sampling edge.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= clk_stop_pkg::PWR_LOCK;
      lock_cnt_r <= 14'h0000;
    end else begin
      case (state_r)
        clk_stop_pkg::PWR_RUN: begin
          if (pd_cnt_r == clk_stop_pkg::DEBOUNCE_EDGES) begin
            state_r <= clk_stop_pkg::PWR_PARK;
          end
        end
        clk_stop_pkg::PWR_PARK: begin
          if (power_down_n) begin
            state_r <= clk_stop_pkg::PWR_RUN;
          end else if (comp_fall) begin
            state_r <= clk_stop_pkg::PWR_DOWN;
          end
        end
        clk_stop_pkg::PWR_DOWN: begin
          lock_cnt_r <= 14'h0000;
          if (power_down_n) begin
            state_r <= clk_stop_pkg::PWR_LOCK;
          end
        end
        clk_stop_pkg::PWR_LOCK: begin
          if (!power_down_n) begin
            state_r <= clk_stop_pkg::PWR_DOWN;
          end else if (int'(lock_cnt_r) >= LOCK_CYCLES - 1) begin
            state_r <= clk_stop_pkg::PWR_RUN;
          end else begin
            lock_cnt_r <= lock_cnt_r + 14'h0001;
          end
        end
        default: state_r <= clk_stop_pkg::PWR_LOCK;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pll_locked <= 1'b0;
    end else begin
      pll_locked <= (state_r == clk_stop_pkg::PWR_RUN) || (state_r == clk_stop_pkg::PWR_PARK);
    end
  end

  // ==========================================================================
  // Output-stop debounce
  logic stop_samp_r;
  logic stop_act_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      stop_samp_r <= 1'b1;
      stop_act_r <= 1'b0;
    end else if (comp_rise) begin
      stop_samp_r <= output_stop_n;
      if (stop_samp_r == output_stop_n) begin
        stop_act_r <= ~output_stop_n;
      end
    end
  end

  // ==========================================================================
  // Per-pair gating
  logic [3:0] stopped_r;
  logic running;

  assign running = (state_r == clk_stop_pkg::PWR_RUN) || (state_r == clk_stop_pkg::PWR_PARK);

  for (genvar i = 0; i < clk_stop_pkg::NUM_OUT; i++) begin : g_pair
    localparam int POS = (i < 2) ? i + 1 : i + 3;
    // Halting only while the true clock is high keeps the last pulse whole.
    always_ff @(posedge mclk) begin
      if (rst || !running || !stoppable_r[POS]) begin
        stopped_r[i] <= 1'b0;
      end else if (base_r) begin
        stopped_r[i] <= stop_act_r;
      end
    end

    always_ff @(posedge mclk) begin
      if (rst) begin
        diff_out_true[i] <= 1'b0;
        diff_out_true_oe[i] <= 1'b0;
        diff_out_comp[i] <= 1'b0;
        diff_out_comp_oe[i] <= 1'b0;
        true_half_drive[i] <= 1'b0;
      end else if (state_r == clk_stop_pkg::PWR_LOCK) begin
        diff_out_true[i] <= 1'b1;
        diff_out_true_oe[i] <= 1'b1;
        diff_out_comp[i] <= 1'b0;
        diff_out_comp_oe[i] <= 1'b0;
        true_half_drive[i] <= 1'b1;
      end else if (state_r == clk_stop_pkg::PWR_DOWN) begin
        diff_out_true[i] <= ~powerdown_drive_sel;
        diff_out_true_oe[i] <= ~powerdown_drive_sel;
        diff_out_comp[i] <= 1'b0;
        diff_out_comp_oe[i] <= 1'b0;
        true_half_drive[i] <= ~powerdown_drive_sel;
      end else if (!enable_r[POS]) begin
        diff_out_true[i] <= 1'b0;
        diff_out_true_oe[i] <= 1'b0;
        diff_out_comp[i] <= 1'b0;
        diff_out_comp_oe[i] <= 1'b0;
        true_half_drive[i] <= 1'b0;
      end else if (stopped_r[i]) begin
        // On release the true output is driven high until it rejoins.
        diff_out_true[i] <= ~stop_mode | ~stop_act_r;
        diff_out_true_oe[i] <= ~stop_mode | ~stop_act_r;
        diff_out_comp[i] <= 1'b0;
        diff_out_comp_oe[i] <= 1'b0;
        true_half_drive[i] <= 1'b0;
      end else begin
        diff_out_true[i] <= base_r;
        diff_out_true_oe[i] <= 1'b1;
        diff_out_comp[i] <= ~base_r;
        diff_out_comp_oe[i] <= 1'b1;
        true_half_drive[i] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_pd_debounce: assert property ((state_r == clk_stop_pkg::PWR_RUN && comp_rise
    && !power_down_n && pd_cnt_r == 2'h1) |=> ##1 state_r == clk_stop_pkg::PWR_PARK)
    else $error("power-down not taken after two low samples");
  chk_pd_no_early: assert property ((state_r == clk_stop_pkg::PWR_RUN && pd_cnt_r == 2'h0)
    |=> state_r == clk_stop_pkg::PWR_RUN)
    else $error("power-down taken on a single sample");
  chk_park_on_fall: assert property ((state_r == clk_stop_pkg::PWR_PARK && !power_down_n
    && comp_fall) |=> state_r == clk_stop_pkg::PWR_DOWN)
    else $error("outputs not parked on complement fall");
  chk_powerdown_drive_sel_drive: assert property ((state_r == clk_stop_pkg::PWR_DOWN && !powerdown_drive_sel)
    |=> diff_out_true_oe == 4'hF && diff_out_true == 4'hF && diff_out_comp_oe == 4'h0
    && true_half_drive == 4'hF)
    else $error("power-down drive mode 0 levels wrong");
  chk_powerdown_drive_sel_tri: assert property ((state_r == clk_stop_pkg::PWR_DOWN && powerdown_drive_sel)
    |=> diff_out_true_oe == 4'h0 && diff_out_comp_oe == 4'h0)
    else $error("power-down drive mode 1 not tri-stated");
  chk_pd_exit: assert property ((state_r == clk_stop_pkg::PWR_DOWN && power_down_n)
    |=> state_r == clk_stop_pkg::PWR_LOCK ##1 diff_out_true_oe == 4'hF)
    else $error("power-down release not taken");
  chk_lock_bound: assert property (int'(lock_cnt_r) < LOCK_CYCLES)
    else $error("lock counter passed its limit");
  chk_stop_stable: assert property ($changed(stop_act_r) |-> $past(comp_rise)
    && $past(stop_samp_r) == $past(output_stop_n))
    else $error("stop accepted without two stable samples");
  chk_stop_high: assert property ($rose(stopped_r[0]) |-> $past(base_r))
    else $error("output halted while its clock was low");
  chk_free_run: assert property ((stopped_r & ~$past({stoppable_r[6:5], stoppable_r[2:1]}))
    == 4'h0)
    else $error("free-running output stopped");
  chk_stop_mode0: assert property ((stopped_r[0] && stop_act_r && !stop_mode && enable_r[1]
    && running) |=> diff_out_true[0] && diff_out_true_oe[0] && !diff_out_comp_oe[0])
    else $error("stopped pair not high in drive mode 0");
  chk_stop_mode1: assert property ((stopped_r[0] && stop_act_r && stop_mode && enable_r[1]
    && running) |=> !diff_out_true_oe[0] && !diff_out_comp_oe[0])
    else $error("stopped pair driven in drive mode 1");
  chk_stop_release: assert property ((stopped_r[0] && !stop_act_r && enable_r[1] && running)
    |=> diff_out_true[0] && diff_out_true_oe[0])
    else $error("released output not driven high");
  chk_id_fixed: assert property (reg_addr == clk_stop_pkg::OFS_REV_VENDOR
    |=> reg_rdata == {clk_stop_pkg::REVISION_CODE, clk_stop_pkg::VENDOR_CODE})
    else $error("revision and vendor byte changed");

  cov_pd_cycle: cover property (state_r == clk_stop_pkg::PWR_DOWN
    ##[1:50] state_r == clk_stop_pkg::PWR_LOCK);
  cov_stop_cycle: cover property ($rose(stopped_r[0]) ##[1:200] $fell(stopped_r[0]));
  cov_stop_tri: cover property (stopped_r[3] && stop_mode && stop_act_r);
endmodule : diff_clock_stop_powerdown_ctrl
`default_nettype wire

// File: test/ref_clock_source.sv
// Host-side model that supplies the reference clock to the clock buffer.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source #(
  parameter int HALF = 4,
  parameter int STOP_DELAY = 64
) (
  // Clock
  input wire logic mclk,
  // Pin level driven by the host
  input wire logic power_down_n,
  // Reference clock
  output logic ref_clock_in
);
  int phase_cnt = 0;
  int pd_cnt = 0;
  // ==========================================================================
  // Clock generation
  // The clock is removed only well after power-down is asserted, so the
  // device can park its outputs first; it stands still while removed.
  initial ref_clock_in = 1'b0;
  always @(posedge mclk) begin
    pd_cnt <= power_down_n ? 0 : pd_cnt + 1;
    if (pd_cnt < STOP_DELAY) begin
      phase_cnt <= (phase_cnt == HALF - 1) ? 0 : phase_cnt + 1;
      if (phase_cnt == HALF - 1) begin
        ref_clock_in <= ~ref_clock_in;
      end
    end
  end
endmodule : ref_clock_source
`default_nettype wire

// File: test/diff_clock_stop_powerdown_ctrl_tb.sv
// Self-checking testbench for the clock stop and power-down controller.
`timescale 1ns/1ps
`default_nettype none
module diff_clock_stop_powerdown_ctrl_tb;
  localparam int LOCKN = 20;
  logic mclk, rst, power_down_n, output_stop_n, reg_wr, ref_clock_in, pll_locked, split;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] diff_out_true, diff_out_true_oe, diff_out_comp, diff_out_comp_oe, true_half_drive;
  logic [3:0] moved;
  int bad_count = 0;
  int checks_done = 0;
  // ==========================================================================
  // Clock and instances
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  ref_clock_source ref_clock_source_inst (
    .mclk(mclk),
    .power_down_n(power_down_n),
    .ref_clock_in(ref_clock_in)
  );
  diff_clock_stop_powerdown_ctrl #(.LOCK_CYCLES(LOCKN)) diff_clock_stop_powerdown_ctrl_inst (
    .mclk(mclk),
    .rst(rst),
    .ref_clock_in(ref_clock_in),
    .power_down_n(power_down_n),
    .output_stop_n(output_stop_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata),
    .diff_out_true(diff_out_true),
    .diff_out_true_oe(diff_out_true_oe),
    .diff_out_comp(diff_out_comp),
    .diff_out_comp_oe(diff_out_comp_oe),
    .true_half_drive(true_half_drive),
    .pll_locked(pll_locked)
  );
  // ==========================================================================
  // Tasks
  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    check(32'(reg_rdata), 32'(exp));
  endtask : rd_chk
  // Records which true outputs toggled, and whether pairs 0 and 3 ever differed.
  task automatic watch(input int n);
    logic [3:0] last;
    moved = 4'h0;
    split = 1'b0;
    last = diff_out_true;
    repeat (n) begin
      @(negedge mclk);
      moved |= diff_out_true ^ last;
      last = diff_out_true;
      if (diff_out_true[0] !== diff_out_true[3]) begin
        split = 1'b1;
      end
    end
  endtask : watch
  // Bounded wait for lock (sel 1) or for pair 0 to be driven again (sel 0).
  task automatic wait_for(input int sel, input int lim);
    int k;
    k = 0;
    while (!(sel ? pll_locked === 1'b1 : diff_out_true_oe[0] === 1'b1) && k < lim) begin
      @(negedge mclk);
      k++;
    end
    if (!(sel ? pll_locked === 1'b1 : diff_out_true_oe[0] === 1'b1)) begin
      bad_count++;
      give_verdict();
    end
  endtask : wait_for
  // Bounded wait for the reference to fall, so that the next rising edge of
  // the system clock is a complement rising edge.
  task automatic to_comp_rise();
    int k;
    k = 0;
    while (ref_clock_in !== 1'b1 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    while (ref_clock_in !== 1'b0 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    if (ref_clock_in !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
  endtask : to_comp_rise
  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    power_down_n = 1'b1;
    output_stop_n = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    rd_chk(clk_stop_pkg::OFS_MODE, 8'h07);
    rd_chk(clk_stop_pkg::OFS_REV_VENDOR, {clk_stop_pkg::REVISION_CODE, clk_stop_pkg::VENDOR_CODE});
    rd_chk(clk_stop_pkg::OFS_PART_ID, clk_stop_pkg::PART_ID_RST);
    rd_chk(clk_stop_pkg::OFS_BYTE_COUNT, 8'h07);
    rd_chk(8'hC3, 8'h00);
    rd_chk(clk_stop_pkg::OFS_ENABLE, clk_stop_pkg::ENABLE_RST);
    rd_chk(clk_stop_pkg::OFS_STOPPABLE, clk_stop_pkg::STOPPABLE_RST);
    wr(clk_stop_pkg::OFS_REV_VENDOR, 8'hFF);
    rd_chk(clk_stop_pkg::OFS_REV_VENDOR, {clk_stop_pkg::REVISION_CODE, clk_stop_pkg::VENDOR_CODE});
    wr(clk_stop_pkg::OFS_PART_ID, 8'hA5);
    rd_chk(clk_stop_pkg::OFS_PART_ID, 8'hA5);
    wr(clk_stop_pkg::OFS_BYTE_COUNT, 8'hF8);
    rd_chk(clk_stop_pkg::OFS_BYTE_COUNT, 8'hF8);
    wait_for(1, LOCKN + 10);
    // Pairs 0 and 3 stoppable, pairs 1 and 2 free-running.
    wr(clk_stop_pkg::OFS_STOPPABLE, 8'h42);
    // Glitches low across exactly one complement rising edge must be ignored.
    to_comp_rise();
    output_stop_n = 1'b0;
    power_down_n = 1'b0;
    @(negedge mclk);
    output_stop_n = 1'b1;
    power_down_n = 1'b1;
    watch(32);
    check(32'(moved), 32'h0F);
    check(32'(pll_locked), 32'h1);
    check(32'({diff_out_comp, diff_out_comp_oe}), 32'({~diff_out_true, 4'hF}));
    for (int m = 0; m < 2; m++) begin
      wr(clk_stop_pkg::OFS_MODE, (m != 0) ? 8'h47 : 8'h07);
      output_stop_n = 1'b0;
      repeat (40) @(negedge mclk);
      check(32'({diff_out_true_oe[0], diff_out_comp_oe[0]}), (m != 0) ? 32'h0 : 32'h2);
      if (m == 0) begin
        check(32'(diff_out_true[0]), 32'h1);
      end
      watch(16);
      check(32'(moved), 32'h06);
      output_stop_n = 1'b1;
      if (m != 0) begin
        wait_for(0, 40);
        check(32'(diff_out_true[0]), 32'h1);
      end
      watch(64);
      check(32'({split, moved}), 32'h0F);
    end
    // A disabled pair is left undriven.
    wr(clk_stop_pkg::OFS_ENABLE, 8'h62);
    repeat (2) @(negedge mclk);
    check(32'({diff_out_true[1], diff_out_true_oe[1], diff_out_comp_oe[1]}), 32'h0);
    wr(clk_stop_pkg::OFS_ENABLE, clk_stop_pkg::ENABLE_RST);
    for (int m = 0; m < 2; m++) begin
      wr(clk_stop_pkg::OFS_MODE, (m != 0) ? 8'h87 : 8'h07);
      power_down_n = 1'b0;
      repeat (80) @(negedge mclk);
      check(32'(pll_locked), 32'h0);
      check(32'({diff_out_true_oe, diff_out_comp_oe}), (m != 0) ? 32'h00 : 32'hF0);
      if (m == 0) begin
        check(32'({diff_out_true, true_half_drive}), 32'hFF);
      end
      power_down_n = 1'b1;
      repeat (2) @(negedge mclk);
      check(32'({diff_out_true, diff_out_true_oe}), 32'hFF);
      wait_for(1, LOCKN + 10);
    end
    give_verdict();
  end
endmodule : diff_clock_stop_powerdown_ctrl_tb
`default_nettype wire
